// File: aio_field_model.sv
// Purpose: far side: retained level cell seen across power-off
// Assumes: cell is backed up, so reset never wipes it
// Notes: capture stops while the device is held in reset
`timescale 1ns/10ps
module aio_field_model
(
    input wire logic pclk, // system clock
    input wire logic presetn, // device reset, active low
    input wire logic last_lvl_out, // level offered for retention
    output logic last_lvl_in // retained level back to device
);
    initial last_lvl_in = 1'b0;
    always @(posedge pclk)
    begin
        if (presetn)
            last_lvl_in <= last_lvl_out;
    end
endmodule : aio_field_model

// File: aio_pkg.sv
// Purpose: constants and types for the alarm input/output block
// Assumes: 20 MHz pclk, 32-bit apb with word registers
// Notes: timing counts derive from the 1 ms tick
package aio_pkg;
    localparam int unsigned CLK_HZ = 20000000;
    localparam int unsigned TICK_MS = 1;
    localparam int unsigned TICK_CYC = CLK_HZ / 1000 * TICK_MS;
    localparam int unsigned DLY_UNIT_MS = 100;
    localparam int unsigned HOLD_UNIT_MS = 1000;
    localparam int unsigned DLY_MAX_MS = 300000;
    localparam int unsigned HOLD_MAX_S = 3000;
    localparam int unsigned WIDTH_MAX_MS = 3000;

    // register byte offsets
    localparam logic [7:0] OFS_SENSE_CTRL = 8'h00;
    localparam logic [7:0] OFS_THRESH = 8'h04;
    localparam logic [7:0] OFS_DRIVE_CTRL = 8'h08;
    localparam logic [7:0] OFS_DELAY = 8'h0c;
    localparam logic [7:0] OFS_HOLD = 8'h10;
    localparam logic [7:0] OFS_LOW_W = 8'h14;
    localparam logic [7:0] OFS_HIGH_W = 8'h18;
    localparam logic [7:0] OFS_STATUS = 8'h1c;
    localparam logic [7:0] OFS_COUNT = 8'h20;
    localparam logic [7:0] OFS_CMD = 8'h24;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h28;
    localparam logic [7:0] OFS_IRQ_CLR = 8'h2c;
    localparam logic [7:0] OFS_IRQ_EN = 8'h30;
    localparam logic [7:0] OFS_LAST = 8'h34;

    // sense control bits
    localparam int unsigned SC_EN = 0;
    localparam int unsigned SC_MODE = 1;
    localparam int unsigned SC_INV = 2;
    // drive control fields
    localparam int unsigned DC_EN = 0;
    localparam int unsigned DC_ON_LSB = 1;
    localparam int unsigned DC_OFF_LSB = 3;
    localparam int unsigned DC_INIT_LSB = 5;
    localparam int unsigned CMD_CLR = 0;
    localparam int unsigned LAST_LVL = 0;

    // irq status bits
    localparam int unsigned IRQ_ALM_ON = 0;
    localparam int unsigned IRQ_ALM_OFF = 1;
    localparam int unsigned IRQ_THR = 2;
    localparam int unsigned IRQ_W = 3;

    localparam logic [1:0] ACT_HIGH = 2'h0;
    localparam logic [1:0] ACT_LOW = 2'h1;
    localparam logic [1:0] ACT_PULSE = 2'h2;
    localparam logic [1:0] INIT_LAST = 2'h0;
    localparam logic [1:0] INIT_HIGH = 2'h1;
    localparam logic [1:0] INIT_LOW = 2'h2;

    localparam logic [31:0] THRESH_RST = 32'h0;
    localparam logic [15:0] DELAY_RST = 16'h0;
    localparam logic [15:0] HOLD_RST = 16'h0;
    localparam logic [15:0] LOW_W_RST = 16'h3e8;
    localparam logic [15:0] HIGH_W_RST = 16'h3e8;

    typedef struct packed {
        logic [1:0] init_sel;
        logic [1:0] off_act;
        logic [1:0] on_act;
        logic enable;
    } aio_drive_cfg_t;

    typedef struct packed {
        logic inv;
        logic counter_mode;
        logic enable;
    } aio_sense_cfg_t;

    typedef enum logic [1:0] {
        AIO_IDLE,
        AIO_DELAY,
        AIO_RUN,
        AIO_DONE
    } aio_act_state_t;
endpackage : aio_pkg

// File: aio_top.sv
// Purpose: sense input alarm logic driving one controlled output
// Assumes: single pclk domain, apb slave, 1 ms tick from pclk
// Notes: last level is kept in a register held by always-on supply
//
// Behaviour
// - sense input disabled after reset until enabled
// - level mode default; alarm follows input
// - counter counts rising, falling when inverted
// - counter alarm when count reaches threshold
// - alarm active high, inversion makes active low
// - output disabled after reset, reacts when enabled
// - alarm on: high default, low, pulse
// - alarm off: high, low default, pulse
// - power-on state always last: init_sel is read while still at its reset value
// - start delay in 100 ms units
// - hold time stops action; zero runs forever
// - pulse low phase lasts low width
// - pulse high phase lasts high width
// - square wave only when pulse selected
// - only source is first input alarm
// - clear resets count; states readable
`timescale 1ns/10ps
module aio_top
    import aio_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = TICK_CYC
)
(
    input wire logic pclk, // system clock
    input wire logic presetn, // async reset, active low
    input wire logic clk_en, // freezes all state while low
    input wire logic psel, // apb select
    input wire logic penable, // apb access phase
    input wire logic pwrite, // apb direction
    input wire logic [7:0] paddr, // apb byte address
    input wire logic [31:0] pwdata, // apb write data
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error on unmapped address
    input wire logic sense_input, // field input pin
    input wire logic last_lvl_in, // retained level at power-on
    output logic drive_out, // controlled output pin
    output logic last_lvl_out, // level to retain across power-off
    output logic irq // level interrupt
);
    import aio_pkg::*;

    aio_sense_cfg_t scfg_r;
    aio_drive_cfg_t dcfg_r;
    logic [31:0] thresh_r;
    logic [15:0] delay_r, hold_r, low_w_r, high_w_r;
    logic [IRQ_W-1:0] irq_stat_r, irq_en_r, irq_set;
    logic [31:0] count_r;
    logic sync1_r, sync2_r, prev_r;
    logic alarm_r, cnt_alarm_r;
    logic [31:0] tick_cnt_r;
    logic tick_r;
    logic clr_cmd;
    logic init_done_r;
    aio_act_state_t st_r;
    logic [31:0] dly_cnt_r, hold_cnt_r, ph_cnt_r;
    logic [1:0] act_r;
    logic ph_hi_r;

    wire acc = psel && penable && clk_en;
    wire wr = acc && pwrite;
    wire rd_ok = (paddr <= OFS_LAST) && (paddr[1:0] == 2'h0);

    // registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            scfg_r <= '0;
            // off action defaults to low, on action to high
            dcfg_r <= '{init_sel: INIT_LAST, off_act: ACT_LOW,
                        on_act: ACT_HIGH, enable: 1'b0};
            thresh_r <= THRESH_RST;
            delay_r <= DELAY_RST;
            hold_r <= HOLD_RST;
            low_w_r <= LOW_W_RST;
            high_w_r <= HIGH_W_RST;
            irq_en_r <= '0;
        end
        else if (wr)
        begin
            case (paddr)
                OFS_SENSE_CTRL: scfg_r <= pwdata[2:0];
                OFS_THRESH: thresh_r <= pwdata;
                OFS_DRIVE_CTRL: dcfg_r <= pwdata[6:0];
                OFS_DELAY: delay_r <= pwdata[15:0];
                OFS_HOLD: hold_r <= pwdata[15:0];
                OFS_LOW_W: low_w_r <= pwdata[15:0];
                OFS_HIGH_W: high_w_r <= pwdata[15:0];
                OFS_IRQ_EN: irq_en_r <= pwdata[IRQ_W-1:0];
                default: ;
            endcase
        end
    end

    assign clr_cmd = wr && (paddr == OFS_CMD) && pwdata[CMD_CLR];

    // apb answer; zero wait states
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata <= 32'h0;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
        else if (clk_en)
        begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && !rd_ok;
            prdata <= 32'h0;
            if (psel && !penable && !pwrite)
            begin
                case (paddr)
                    OFS_SENSE_CTRL: prdata <= {29'h0, scfg_r};
                    OFS_THRESH: prdata <= thresh_r;
                    OFS_DRIVE_CTRL: prdata <= {25'h0, dcfg_r};
                    OFS_DELAY: prdata <= {16'h0, delay_r};
                    OFS_HOLD: prdata <= {16'h0, hold_r};
                    OFS_LOW_W: prdata <= {16'h0, low_w_r};
                    OFS_HIGH_W: prdata <= {16'h0, high_w_r};
                    OFS_STATUS: prdata <= {29'h0, drive_out, alarm_r,
                        sync2_r};
                    OFS_COUNT: prdata <= count_r;
                    OFS_IRQ_STAT: prdata <= {29'h0, irq_stat_r};
                    OFS_IRQ_EN: prdata <= {29'h0, irq_en_r};
                    default: prdata <= 32'h0;
                endcase
            end
        end
    end

    // 1 ms tick
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            tick_cnt_r <= 32'h0;
            tick_r <= 1'b0;
        end
        else if (clk_en)
        begin
            tick_r <= (tick_cnt_r == TICK_CYCLES - 1);
            if (tick_cnt_r == TICK_CYCLES - 1)
                tick_cnt_r <= 32'h0;
            else
                tick_cnt_r <= tick_cnt_r + 32'h1;
        end
    end

    // two-stage synchroniser, then edge history
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sync1_r <= 1'b0;
            sync2_r <= 1'b0;
            prev_r <= 1'b0;
        end
        else if (clk_en)
        begin
            sync1_r <= sense_input;
            sync2_r <= sync1_r;
            prev_r <= sync2_r;
        end
    end

    wire active_lvl = sync2_r ^ scfg_r.inv;
    // counted edge: rising normally, falling with inversion
    wire edge_hit = scfg_r.inv ? (prev_r && !sync2_r)
                               : (!prev_r && sync2_r);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            count_r <= 32'h0;
            cnt_alarm_r <= 1'b0;
        end
        else if (clk_en)
        begin
            if (clr_cmd)
            begin
                count_r <= 32'h0;
                cnt_alarm_r <= 1'b0;
            end
            else if (scfg_r.enable && scfg_r.counter_mode)
            begin
                if (edge_hit && count_r != 32'hffffffff)
                    count_r <= count_r + 32'h1;
                if (count_r >= thresh_r)
                    cnt_alarm_r <= 1'b1;
            end
        end
    end

    // input alarm, the only output source
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            alarm_r <= 1'b0;
        else if (clk_en)
        begin
            if (!scfg_r.enable)
                alarm_r <= 1'b0;
            else if (scfg_r.counter_mode)
                alarm_r <= cnt_alarm_r;
            else
                alarm_r <= active_lvl;
        end
    end

    logic alarm_d_r;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            alarm_d_r <= 1'b0;
        else if (clk_en)
            alarm_d_r <= alarm_r;
    end
    wire alarm_rise = alarm_r && !alarm_d_r;
    wire alarm_fall = !alarm_r && alarm_d_r;
    wire trig = dcfg_r.enable && (alarm_rise || alarm_fall);

    // action sequencer: delay, then level or pulse train, until hold ends
    wire [31:0] dly_ms = {16'h0, delay_r} * DLY_UNIT_MS;
    wire [31:0] hold_ms = {16'h0, hold_r} * HOLD_UNIT_MS;
    wire [31:0] lw = (low_w_r == 16'h0) ? 32'h1 : {16'h0, low_w_r};
    wire [31:0] hw = (high_w_r == 16'h0) ? 32'h1 : {16'h0, high_w_r};

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st_r <= AIO_IDLE;
            act_r <= ACT_LOW;
            dly_cnt_r <= 32'h0;
            hold_cnt_r <= 32'h0;
            ph_cnt_r <= 32'h0;
            ph_hi_r <= 1'b0;
        end
        else if (clk_en)
        begin
            if (trig)
            begin
                // a new action always replaces the running one
                act_r <= alarm_rise ? dcfg_r.on_act
                                    : dcfg_r.off_act;
                dly_cnt_r <= 32'h0;
                hold_cnt_r <= 32'h0;
                ph_cnt_r <= 32'h0;
                ph_hi_r <= 1'b1;
                st_r <= (delay_r == 16'h0) ? AIO_RUN : AIO_DELAY;
            end
            else if (!dcfg_r.enable)
                st_r <= AIO_IDLE;
            else if (tick_r)
            begin
                case (st_r)
                    AIO_DELAY:
                    begin
                        if (dly_cnt_r + 32'h1 >= dly_ms)
                            st_r <= AIO_RUN;
                        dly_cnt_r <= dly_cnt_r + 32'h1;
                    end
                    AIO_RUN:
                    begin
                        hold_cnt_r <= hold_cnt_r + 32'h1;
                        if (hold_r != 16'h0 && hold_cnt_r + 32'h1 >= hold_ms)
                            st_r <= AIO_DONE;
                        if (act_r == ACT_PULSE)
                        begin
                            if (ph_cnt_r + 32'h1 >= (ph_hi_r ? hw : lw))
                            begin
                                ph_cnt_r <= 32'h0;
                                ph_hi_r <= !ph_hi_r;
                            end
                            else
                                ph_cnt_r <= ph_cnt_r + 32'h1;
                        end
                    end
                    default: ;
                endcase
            end
        end
    end

    // output pin with power-on initial state
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            drive_out <= 1'b0;
            init_done_r <= 1'b0;
        end
        else if (clk_en)
        begin
            if (!init_done_r)
            begin
                // strap sampled after release, one cycle to settle
                init_done_r <= 1'b1;
                case (dcfg_r.init_sel)
                    INIT_HIGH: drive_out <= 1'b1;
                    INIT_LOW: drive_out <= 1'b0;
                    default: drive_out <= last_lvl_in;
                endcase
            end
            else if (st_r == AIO_RUN)
            begin
                case (act_r)
                    ACT_HIGH: drive_out <= 1'b1;
                    ACT_LOW: drive_out <= 1'b0;
                    ACT_PULSE: drive_out <= ph_hi_r;
                    default: drive_out <= drive_out;
                endcase
            end
        end
    end

    // retained copy follows each change of the pin
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            last_lvl_out <= 1'b0;
        else if (clk_en && init_done_r)
            last_lvl_out <= drive_out;
    end

    // interrupts: set wins over clear
    // threshold event: the cycle in which the counter alarm gets set
    assign irq_set = {!cnt_alarm_r && !clr_cmd && scfg_r.enable
                      && scfg_r.counter_mode && count_r >= thresh_r,
                      alarm_fall, alarm_rise};
    wire [IRQ_W-1:0] irq_clr = (wr && paddr == OFS_IRQ_CLR)
        ? pwdata[IRQ_W-1:0] : '0;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            irq_stat_r <= '0;
            irq <= 1'b0;
        end
        else if (clk_en)
        begin
            irq_stat_r <= (irq_stat_r & ~irq_clr) | irq_set;
            irq <= |(((irq_stat_r & ~irq_clr) | irq_set) & irq_en_r);
        end
    end
endmodule : aio_top

// File: aio_top_properties.sv
// Purpose: port-level checks for the alarm input/output block
// Assumes: one pclk domain, clk_en held high by the bench
// Notes: bound onto aio_top below the checker
`timescale 1ns/10ps
module aio_top_checker
    import aio_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = TICK_CYC
)
(
    input wire logic pclk, // system clock
    input wire logic presetn, // async reset, active low
    input wire logic clk_en, // state enable
    input wire logic psel, // apb select
    input wire logic penable, // apb access phase
    input wire logic pwrite, // apb direction
    input wire logic [7:0] paddr, // apb byte address
    input wire logic [31:0] pwdata, // apb write data
    input wire logic [31:0] prdata, // apb read data
    input wire logic pready, // apb ready
    input wire logic pslverr, // apb error
    input wire logic sense_input, // field input pin
    input wire logic last_lvl_in, // retained level
    input wire logic drive_out, // controlled output
    input wire logic last_lvl_out, // level to retain
    input wire logic irq // level interrupt
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    sequence s_setup;
        psel && !penable && clk_en;
    endsequence
    sequence s_wr_access;
        psel && penable && pwrite;
    endsequence
    property p_ready_after_setup;
        s_setup |=> pready;
    endproperty
    property p_ready_single;
        pready |=> !pready;
    endproperty
    property p_ready_cause;
        pready |-> $past(psel && !penable);
    endproperty
    property p_err_with_ready;
        pslverr |-> pready;
    endproperty
    property p_err_reads_zero;
        pready && pslverr && !pwrite |-> prdata == 32'h0;
    endproperty
    property p_wo_reads_zero;
        pready && !pwrite && (paddr == OFS_CMD || paddr == OFS_IRQ_CLR)
            |-> prdata == 32'h0;
    endproperty
    property p_last_copy;
        $changed(drive_out) |=> last_lvl_out == $past(drive_out);
    endproperty
    property p_init_last;
        $rose(presetn) |=> drive_out == $past(last_lvl_in);
    endproperty
    // irq only drops after software wrote clear or enable
    property p_irq_fall;
        $fell(irq) |-> $past(psel && penable && pwrite) ||
            $past(psel && penable && pwrite, 2) ||
            $past(psel && penable && pwrite, 3);
    endproperty
    a_ready_after_setup: assert property (p_ready_after_setup)
        else $error("no ready in access cycle");
    a_ready_single: assert property (p_ready_single)
        else $error("ready held two cycles");
    a_ready_cause: assert property (p_ready_cause)
        else $error("ready without setup");
    a_err_with_ready: assert property (p_err_with_ready)
        else $error("error without ready");
    a_err_reads_zero: assert property (p_err_reads_zero)
        else $error("refused read returned data");
    a_wo_reads_zero: assert property (p_wo_reads_zero)
        else $error("write-only register read nonzero");
    a_last_copy: assert property (p_last_copy)
        else $error("retained level not following output");
    a_init_last: assert property (p_init_last)
        else $error("output not restored at power-on");
    a_irq_fall: assert property (p_irq_fall)
        else $error("irq dropped with no write");
endmodule : aio_top_checker

bind aio_top aio_top_checker #(.TICK_CYCLES(TICK_CYCLES)) i_chk (
    .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sense_input(sense_input), .last_lvl_in(last_lvl_in),
    .drive_out(drive_out), .last_lvl_out(last_lvl_out), .irq(irq));

// File: testbench.sv
// Purpose: self-checking bench for the alarm input/output block
// Assumes: tick shortened to 4 cycles, so 1 ms is 4 pclk
// Notes: register rows first, then hand-written cases
`timescale 1ns/10ps
`define CHK(g, x) begin samples_checked++; if ((g) !== (x)) begin \
    fails++; $display("unexpected %0t: got %h want %h", $time, g, x); \
    end end
module testbench;
    import aio_pkg::*;
    localparam int TK = 4;
    typedef struct packed {
        logic [7:0] a;
        logic w;
        logic [31:0] d;
        logic e;
    } aio_row_t;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic sense_input = 0, pready, pslverr, drive_out, last_lvl_out;
    logic irq, last_lvl_in, er;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    int fails = 0, samples_checked = 0, cyc = 0, c;
    // reads carry expected data in d, writes carry the data to write
    aio_row_t rows [10] = '{'{8'h00, 1'h0, 32'h0, 1'h0},
        '{8'h04, 1'h0, 32'h0, 1'h0}, '{8'h08, 1'h0, 32'h8, 1'h0},
        '{8'h0c, 1'h0, 32'h0, 1'h0}, '{8'h10, 1'h0, 32'h0, 1'h0},
        '{8'h18, 1'h0, 32'h3e8, 1'h0}, '{8'h24, 1'h0, 32'h0, 1'h0},
        '{8'h3c, 1'h0, 32'h0, 1'h1}, '{8'h04, 1'h1, 32'h3, 1'h0},
        '{8'h04, 1'h0, 32'h3, 1'h0}};
    aio_top #(.TICK_CYCLES(TK)) i_aio_top (.pclk(pclk), .presetn(presetn),
        .clk_en(1'b1), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .sense_input(sense_input),
        .last_lvl_in(last_lvl_in), .drive_out(drive_out),
        .last_lvl_out(last_lvl_out), .irq(irq));
    aio_field_model i_aio_field_model (.pclk(pclk), .presetn(presetn),
        .last_lvl_out(last_lvl_out), .last_lvl_in(last_lvl_in));
    always #25 pclk = ~pclk;
    task automatic give_verdict;
        $display("checked %0d mismatched %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : give_verdict
    // whole run is under a thousand cycles
    always @(posedge pclk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            fails++;
            give_verdict();
        end
    end
    task automatic tk(input int n);
        repeat (n) @(posedge pclk);
    endtask : tk
    task automatic apb(input logic [7:0] a, input logic w,
        input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic run_len(input logic v);
        c = 0;
        while (drive_out === v && c < 1000)
        begin
            @(posedge pclk);
            c++;
        end
    endtask : run_len
    initial
    begin
        tk(20);
        presetn <= 1'b1;
        foreach (rows[i])
        begin
            apb(rows[i].a, rows[i].w, rows[i].d);
            `CHK(er, rows[i].e)
            if (!rows[i].w)
                `CHK(rd, rows[i].d)
        end
        $display("register table done");
        apb(8'h30, 1'h1, 32'h1);
        apb(8'h08, 1'h1, 32'h9);
        sense_input <= 1'b1;
        tk(8 * TK);
        `CHK(drive_out, 1'b0)
        apb(8'h00, 1'h1, 32'h1);
        tk(8 * TK);
        `CHK(drive_out, 1'b1)
        `CHK(irq, 1'b1)
        apb(8'h2c, 1'h1, 32'h1);
        tk(3);
        `CHK(irq, 1'b0)
        sense_input <= 1'b0;
        tk(8 * TK);
        `CHK(drive_out, 1'b0)
        apb(8'h00, 1'h1, 32'h5);
        tk(8 * TK);
        `CHK(drive_out, 1'b1)
        $display("level test done");
        presetn <= 1'b0;
        tk(2);
        presetn <= 1'b1;
        tk(2);
        `CHK(drive_out, 1'b1)
        apb(8'h00, 1'h0, 32'h0);
        `CHK(rd, 32'h0)
        $display("power-on test done");
        apb(8'h04, 1'h1, 32'h3);
        apb(8'h08, 1'h1, 32'h9);
        apb(8'h00, 1'h1, 32'h3);
        apb(8'h24, 1'h1, 32'h1);
        for (int k = 1; k <= 3; k++)
        begin
            sense_input <= 1'b1;
            tk(6);
            sense_input <= 1'b0;
            tk(6);
            apb(8'h20, 1'h0, 32'h0);
            `CHK(rd, 32'(k))
            apb(8'h1c, 1'h0, 32'h0);
            `CHK(rd[1], k == 3)
        end
        tk(4 * TK);
        `CHK(drive_out, 1'b1)
        apb(8'h24, 1'h1, 32'h1);
        tk(4 * TK);
        apb(8'h20, 1'h0, 32'h0);
        `CHK(rd, 32'h0)
        `CHK(drive_out, 1'b0)
        $display("counter test done");
        apb(8'h14, 1'h1, 32'h2);
        apb(8'h18, 1'h1, 32'h3);
        apb(8'h08, 1'h1, 32'hd);
        apb(8'h00, 1'h1, 32'h1);
        sense_input <= 1'b1;
        run_len(1'b0);
        run_len(1'b1);
        run_len(1'b0);
        `CHK(c, 2 * TK)
        run_len(1'b1);
        `CHK(c, 3 * TK)
        $display("pulse test done");
        sense_input <= 1'b0;
        apb(8'h08, 1'h1, 32'h9);
        apb(8'h0c, 1'h1, 32'h1);
        tk(8 * TK);
        sense_input <= 1'b1;
        run_len(1'b0);
        `CHK(c >= 100 * TK && c <= 102 * TK + 8, 1'b1)
        $display("delay test done");
        give_verdict();
    end
endmodule : testbench
